//--- bench/dcc_stage_model.sv
// Switching stage and SAR stand-in: counts ticks and times the tick period.
// Assumes all ticks are single-cycle pulses on core_clk.
`timescale 1ns/1ns
module dcc_stage_model
(
  // Clock
  input  wire logic core_clk,
  // Ticks from the block
  input  wire logic conv_clk_tick,
  input  wire logic sar_clk_tick,
  input  wire logic adc_track_start,
  // Observations
  output int        period,
  output int        conv_cnt,
  output int        sar_cnt,
  output int        trk_cnt
);
  int cyc = 0;

  // Two-state outputs start at zero, so only this process drives them
  // Period is measured edge to edge, so back-to-back ticks read as 1
  always @(posedge core_clk)
  begin
    cyc <= conv_clk_tick ? 0 : cyc + 1;
    if (conv_clk_tick)
    begin
      period <= cyc + 1;
      conv_cnt <= conv_cnt + 1;
    end
    if (sar_clk_tick)
      sar_cnt <= sar_cnt + 1;
    if (adc_track_start)
      trk_cnt <= trk_cnt + 1;
  end
endmodule

//--- bench/tb_dcdc_clock_config.sv
// Self-checking bench for the converter clock/config block.
// Assumes the special-function port contract of the block and one 50 MHz clock.
`timescale 1ns/1ns
module tb_dcdc_clock_config;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sleep_mode = 1'b0;
  logic       conv_enable = 1'b0;
  wire  [7:0] sfr_rdata;
  wire        conv_clk_tick, conv_clk_inverted, sar_clk_tick, sar_clk_inverted;
  wire        adc_track_start, peak_current_high, rail_tie_battery;
  int         period, conv_cnt, sar_cnt, trk_cnt;
  int         err_total = 0;
  int         checked = 0;
  int         cycles = 0;

  always #10 core_clk = ~core_clk;

  dcc_top uut (.core_clk(core_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sleep_mode(sleep_mode),
    .conv_enable(conv_enable), .conv_clk_tick(conv_clk_tick),
    .conv_clk_inverted(conv_clk_inverted), .sar_clk_tick(sar_clk_tick),
    .sar_clk_inverted(sar_clk_inverted), .adc_track_start(adc_track_start),
    .peak_current_high(peak_current_high), .rail_tie_battery(rail_tie_battery));

  dcc_stage_model stage (.core_clk(core_clk), .conv_clk_tick(conv_clk_tick),
    .sar_clk_tick(sar_clk_tick), .adc_track_start(adc_track_start), .period(period),
    .conv_cnt(conv_cnt), .sar_cnt(sar_cnt), .trk_cnt(trk_cnt));

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    @(negedge core_clk);
    d = sfr_rdata;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic test_done;
    $display("mismatches %0d comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Whole run needs about 700 cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      test_done();
    end
  end

  initial
  begin
    logic [7:0] v;
    int         r;
    int         c0;
    int         s0;
    int         t0;
    void'($urandom(32'hb60f));
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h96, v);
    chk(v, 8'h00);
    rd(8'h97, v);
    chk(v, 8'h21);
    // Unmapped address reads as zero
    rd(8'h55, v);
    chk(v, 8'h00);
    // Divider and invert set while the oscillator runs: both must be ignored
    wr(8'h96, 8'h68);
    settle(60);
    chk(8'(period), 8'd20);
    chk({7'h0, conv_clk_inverted}, 8'h00);
    for (int code = 0; code < 4; code++)
    begin
      wr(8'h96, 8'h01 | 8'(code << 5) | (code[0] ? 8'h08 : 8'h00));
      settle(40);
      chk(8'(period), 8'(1 << code));
      chk({7'h0, conv_clk_inverted}, {7'h0, code[0]});
    end
    // Random settings, power states and sync; software keeps bit 7 at zero
    for (int i = 0; i < 8; i++)
    begin
      r = $urandom;
      @(posedge core_clk);
      sleep_mode <= r[8];
      conv_enable <= r[9];
      wr(8'h97, {4'h2, r[10], 3'h1});
      wr(8'h96, {1'b0, r[6:0]});
      rd(8'h96, v);
      chk(v, {1'b0, r[6:0]});
      settle(2);
      c0 = conv_cnt;
      s0 = sar_cnt;
      t0 = trk_cnt;
      chk({5'h0, peak_current_high, rail_tie_battery, sar_clk_inverted},
          {5'h0, r[2], r[8] & r[9] & ~r[1], r[10] & ~r[4]});
      settle(45);
      chk(8'(sar_cnt - s0), r[10] ? 8'(conv_cnt - c0) : 8'h00);
      chk(8'(trk_cnt - t0), r[10] ? 8'(conv_cnt - c0) : 8'h00);
    end
    test_done();
  end
endmodule

//--- verilog/dcc_clk_div.sv
// Power-of-two tick divider for the system clock path.
// Assumes clear is pulsed at a converter clock boundary by the parent.
`timescale 1ns/1ns
module dcc_clk_div
  import dcc_pkg::*;
(
  // Clock and reset
  input  wire logic     core_clk,
  input  wire logic     rst_n,
  // Control
  input  wire logic     clear,
  input  wire dcc_div_e div_code,
  // Divided tick
  output logic          tick
);

  logic [2:0] cnt;
  logic [2:0] last;

  always_comb
  begin
    unique case (div_code)
      DCC_DIV1: last = 3'h0;
      DCC_DIV2: last = 3'h1;
      DCC_DIV4: last = 3'h3;
      DCC_DIV8: last = 3'h7;
    endcase
  end

  assign tick = (cnt == last);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || clear || tick)
      cnt <= 3'h0;
    else
      cnt <= cnt + 3'h1;
  end

endmodule

//--- verilog/dcc_map.svh
// Register offsets, field positions, reset values and timing counts for the
// converter clock/config block. Included by the design files only.
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH

// Register addresses on the special-function bus
`define DCC_ADDR_CFG       8'h96
`define DCC_ADDR_CTRL      8'h97

// Fields of converter_clock_config
`define DCC_CFG_SRC_SEL    0
`define DCC_CFG_SLP_FLOAT  1
`define DCC_CFG_PEAK_LVL   2
`define DCC_CFG_SYS_INV    3
`define DCC_CFG_SAR_INV_N  4
`define DCC_CFG_DIV_LO     5
`define DCC_CFG_DIV_HI     6
`define DCC_CFG_RSVD       7

// Fields of converter_control
`define DCC_CTRL_SYNC      3

// Reset values
`define DCC_CFG_RESET      8'h00
`define DCC_CTRL_RESET     8'h21

// Timing: core clock period and local oscillator period, in picoseconds
`define DCC_CORE_PERIOD_PS 20000
`define DCC_LOSC_PERIOD_PS 416667
// Longest whole number of core cycles inside one oscillator period
`define DCC_LOSC_CYCLES    (`DCC_LOSC_PERIOD_PS / `DCC_CORE_PERIOD_PS)

`endif

//--- verilog/dcc_pkg.sv
// Types shared by the converter clock/config block.
// Assumes the map header supplies all numeric constants.
package dcc_pkg;

  typedef logic [7:0] dcc_byte_t;

  // Divide ratio code of the system clock path
  typedef enum logic [1:0]
  {
    DCC_DIV1 = 2'b00,
    DCC_DIV2 = 2'b01,
    DCC_DIV4 = 2'b10,
    DCC_DIV8 = 2'b11
  } dcc_div_e;

endpackage

//--- verilog/dcc_top.sv
// Converter clock generation and configuration registers.
// Assumes the special-function bus and power-state inputs are on core_clk.
//
// Contract
// - Bit 0 selects the local oscillator (0) or the system clock (1).
// - With the system clock, bits 6:5 divide it by 1, 2, 4 or 8.
// - The divider field has no effect while the local oscillator runs.
// - Bit 3 sets conv_clk_inverted while the system clock is selected; the divider does not see it.
// - With sync on, bit 4 low inverts the SAR clock and high leaves it.
// - The SAR inversion bit is ignored while sync is off.
// - Bit 2 picks the lower (0) or higher (1) peak current threshold.
// - In sleep with the converter on, bit 1 low ties the rail to battery.
// - Bit 7 reads as zero and software writes it as zero.
// - With sync on, ADC tracking and SAR clock follow the switching cycle.
// - The local oscillator ticks every 20 core cycles (2.5 MHz) whenever sysclk is unused.
`timescale 1ns/1ns
`include "dcc_map.svh"
module dcc_top
  import dcc_pkg::*;
(
  // Clock and reset
  input  wire logic      core_clk,
  input  wire logic      rst_n,
  // Special-function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire dcc_byte_t  sfr_wdata,
  output dcc_byte_t       sfr_rdata,
  // Power state
  input  wire logic       sleep_mode,
  input  wire logic       conv_enable,
  // Converter clock
  output logic            conv_clk_tick,
  output logic            conv_clk_inverted,
  // ADC synchronisation
  output logic            sar_clk_tick,
  output logic            sar_clk_inverted,
  output logic            adc_track_start,
  // Switching stage
  output logic            peak_current_high,
  output logic            rail_tie_battery
);

  localparam logic [4:0] LOSC_LAST = 5'(`DCC_LOSC_CYCLES - 1);

  dcc_byte_t converter_clock_config;
  dcc_byte_t converter_control;
  logic      conv_clk_source_sel;
  logic      sysclk_invert;
  dcc_div_e  conv_clk_divider;
  logic [4:0] losc_cnt;
  logic      losc_tick;
  logic      sys_tick;
  logic      next_tick;
  logic      sync_on;

  assign sync_on = converter_control[`DCC_CTRL_SYNC];

  // Register writes; bit 7 of the configuration register is never stored
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      converter_clock_config <= `DCC_CFG_RESET;
      converter_control      <= `DCC_CTRL_RESET;
    end
    else if (sfr_wr)
    begin
      if (sfr_addr == `DCC_ADDR_CFG)
        converter_clock_config <= {1'b0, sfr_wdata[6:0]};
      if (sfr_addr == `DCC_ADDR_CTRL)
        converter_control <= sfr_wdata;
    end
  end

  // Registered read data, zero for unmapped addresses
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
    begin
      if (sfr_addr == `DCC_ADDR_CFG)
        sfr_rdata <= {1'b0, converter_clock_config[6:0]};
      else if (sfr_addr == `DCC_ADDR_CTRL)
        sfr_rdata <= converter_control;
      else
        sfr_rdata <= 8'h00;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || losc_tick)
      losc_cnt <= 5'h00;
    else
      losc_cnt <= losc_cnt + 5'h01;
  end

  assign losc_tick = (losc_cnt == LOSC_LAST);

  dcc_clk_div u_div
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clear    (next_tick),
    .div_code (conv_clk_divider),
    .tick     (sys_tick)
  );

  assign next_tick = conv_clk_source_sel ? sys_tick : losc_tick;

  // Applied settings only move on a tick, so no runt period is produced except when switching back to the free-running local oscillator
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      conv_clk_source_sel <= 1'b0;
      sysclk_invert       <= 1'b0;
      conv_clk_divider    <= DCC_DIV1;
    end
    else if (next_tick)
    begin
      conv_clk_source_sel <= converter_clock_config[`DCC_CFG_SRC_SEL];
      sysclk_invert       <= converter_clock_config[`DCC_CFG_SYS_INV];
      conv_clk_divider    <= dcc_div_e'(converter_clock_config[`DCC_CFG_DIV_HI:`DCC_CFG_DIV_LO]);
    end
  end

  // Converter clock outputs
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      conv_clk_tick     <= 1'b0;
      conv_clk_inverted <= 1'b0;
    end
    else
    begin
      conv_clk_tick     <= next_tick;
      conv_clk_inverted <= conv_clk_source_sel & sysclk_invert;
    end
  end

  // SAR clock and tracking follow the switching cycle only under sync
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sar_clk_tick     <= 1'b0;
      sar_clk_inverted <= 1'b0;
      adc_track_start  <= 1'b0;
    end
    else
    begin
      sar_clk_tick     <= sync_on & next_tick;
      adc_track_start  <= sync_on & next_tick;
      sar_clk_inverted <= sync_on & ~converter_clock_config[`DCC_CFG_SAR_INV_N];
    end
  end

  // Switching stage controls
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      peak_current_high <= 1'b0;
      rail_tie_battery  <= 1'b0;
    end
    else
    begin
      peak_current_high <= converter_clock_config[`DCC_CFG_PEAK_LVL];
      rail_tie_battery  <= sleep_mode & conv_enable
                           & ~converter_clock_config[`DCC_CFG_SLP_FLOAT];
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_SRC_LOSC: assert property (!conv_clk_source_sel && losc_tick |=> conv_clk_tick)
    else $error("oscillator tick not passed to converter clock");

  AST_DIV8: assert property (conv_clk_tick && conv_clk_source_sel &&
      conv_clk_divider == DCC_DIV8 |=> !conv_clk_tick [*7] ##1 conv_clk_tick)
    else $error("divide by eight period wrong");

  AST_DIV_IGNORED: assert property (!conv_clk_source_sel |->
      (next_tick == losc_tick))
    else $error("divider affects oscillator clock");

  AST_INV_PATH: assert property (conv_clk_inverted |->
      $past(conv_clk_source_sel) && $past(sysclk_invert))
    else $error("inversion without sysclk invert");

  AST_SAR_INV: assert property (sync_on &&
      !converter_clock_config[`DCC_CFG_SAR_INV_N] |=> sar_clk_inverted)
    else $error("SAR clock not inverted");

  AST_SAR_NOSYNC: assert property (!sync_on |=> !sar_clk_inverted && !sar_clk_tick)
    else $error("SAR output active without sync");

  AST_PEAK: assert property (##1 peak_current_high ==
      $past(converter_clock_config[`DCC_CFG_PEAK_LVL]))
    else $error("peak level not following register");

  AST_RAIL: assert property (sleep_mode && conv_enable &&
      !converter_clock_config[`DCC_CFG_SLP_FLOAT] |=> rail_tie_battery)
    else $error("rail not tied in sleep");

  // Only the configuration register has a read-as-zero bit 7
  AST_B7_READ: assert property (sfr_rd && sfr_addr == `DCC_ADDR_CFG |=> !sfr_rdata[7])
    else $error("reserved bit read as one");

  AST_LOSC_RATE: assert property (losc_tick |=> !losc_tick [*8])
    else $error("oscillator tick too fast");

  AST_BOUNDARY: assert property ($changed(conv_clk_divider) ||
      $changed(conv_clk_source_sel) |-> $past(next_tick))
    else $error("clock setting moved off boundary");

  AST_RESET_ZERO: assert property (disable iff (1'b0) !rst_n |=>
      converter_clock_config == 8'h00)
    else $error("configuration not cleared by reset");

  COV_SYSCLK: cover property (conv_clk_tick && conv_clk_source_sel);
  COV_SYNC_SAR: cover property (sar_clk_tick && sar_clk_inverted);
  COV_SLEEP_FLOAT: cover property (sleep_mode && conv_enable && !rail_tie_battery);

endmodule
